// >>> shared/slrmc_pkg.sv
package slrmc_pkg;
	// Widths of the lane and register paths
	localparam int NUM_LANES     = 16;
	localparam int WORD_W        = 12;
	localparam int DATA_W        = 8;
	localparam int ADDR_W        = 7;
	localparam int ROWS_W        = 11;

	// Register map, byte-wide registers at their printed offsets
	localparam logic [6:0] ADDR_ROWS_LO  = 7'h01;
	localparam logic [6:0] ADDR_ROWS_HI  = 7'h02;
	localparam logic [6:0] ADDR_STATUS   = 7'h03;
	localparam logic [6:0] ADDR_TRAIN_LO = 7'h4E;
	localparam logic [6:0] ADDR_TRAIN_HI = 7'h4F;
	localparam logic [6:0] ADDR_DIS_LO   = 7'h50;
	localparam logic [6:0] ADDR_DIS_HI   = 7'h51;
	localparam logic [6:0] ADDR_DIS_RSV  = 7'h52;
	localparam logic [6:0] ADDR_SEL_ONE  = 7'h6C;
	localparam logic [6:0] ADDR_SEL_TWO  = 7'h6D;

	// Reset values
	localparam logic [10:0] ROWS_RST  = 11'h440;
	localparam logic [11:0] TRAIN_RST = 12'h000;
	localparam logic [7:0]  SEL_RST   = 8'h00;
	localparam logic [15:0] DIS_RST   = 16'h0000;

	// Status register bit positions
	localparam int ST_FRAME = 0;
	localparam int ST_BUSY  = 1;

	// Lane multiplexing modes
	localparam logic [1:0] MODE_16 = 2'h0;
	localparam logic [1:0] MODE_8  = 2'h1;
	localparam logic [1:0] MODE_4  = 2'h2;
	localparam logic [1:0] MODE_2  = 2'h3;

	// Test pin select codes
	localparam logic [7:0] SEL_INTEGRATING_BLOCK_ONE = 8'h00;
	localparam logic [7:0] SEL_INTEGRATING_BLOCK_TWO = 8'h01;
	localparam logic [7:0] SEL_PIXEL_VALID_FLAG  = 8'h02;
	localparam logic [7:0] SEL_ROW_VALID_FLAG  = 8'h03;
	localparam logic [7:0] SEL_FRAME_VALID_FLAG  = 8'h04;

	// Control word bit positions and constants
	localparam int CB_PIXEL_VALID_FLAG  = 0;
	localparam int CB_ROW_VALID_FLAG  = 1;
	localparam int CB_FRAME_VALID_FLAG  = 2;
	localparam int CB_SLOT  = 3;
	localparam int CB_ROW   = 4;
	localparam int CB_FOT   = 5;
	localparam int CB_INTEGRATING_BLOCK_ONE = 6;
	localparam int CB_INTEGRATING_BLOCK_TWO = 7;
	localparam logic [11:0] CTRL_CONST = 12'h200;
	localparam logic [11:0] MASK_10    = 12'h3FF;
	localparam logic [11:0] MASK_12    = 12'hFFF;
	localparam logic [6:0]  PIX_LAST   = 7'h7F;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_GAP,
		ST_BURST
	} slrmc_state_t;

	// Configuration handed from the register domain to the pixel domain
	typedef struct packed {
		logic [11:0] train;
		logic [7:0]  sel_one;
		logic [7:0]  sel_two;
		logic [10:0] rows;
		logic [15:0] dis;
		logic [1:0]  mode;
		logic        bit12;
	} slrmc_cfg_t;

	typedef struct packed {
		logic [11:0] train;
		logic [7:0]  sel_one;
		logic [7:0]  sel_two;
		logic [10:0] rows;
		logic [15:0] dis;
		slrmc_cfg_t  sh;
		logic        req;
		logic        busy;
		logic        ack_s1;
		logic        ack_s2;
		logic        fv_s1;
		logic        fv_s2;
		logic [7:0]  rdata;
	} slrmc_ref_t;

	typedef struct packed {
		logic         req_s1;
		logic         req_s2;
		logic         ack;
		slrmc_cfg_t   cfg;
		slrmc_state_t st;
		logic [2:0]   slot;
		logic [6:0]   pix;
		logic [10:0]  row;
		logic [191:0] lane;
		logic [11:0]  ctrl;
		logic         tp_one;
		logic         tp_two;
	} slrmc_pix_t;
endpackage : slrmc_pkg

// >>> hw/slrmc_readout.sv
// Summary of operation
// - 12-bit forces sixteen- and eight-lane to four-lane multiplexing
// - 12-bit default four lanes, 516-cycle rows
// - 12-bit two-lane uses eight burst slots
// - Sixteen-lane sends whole row in one slot
// - Rows per frame programmable, default 1088
// - Eight-lane: two slots, odd lanes distinct
// - Per-lane disable bits at 80 and 81
// - Four-lane: lanes 1,5,9,13, four slots
// - Two-lane: lanes 1,9, eight slots
// - All sixteen outputs carry data unless disabled
// - Fixed duplication map for reduced modes
// - Control bits 0-2: data, row, frame valid
// - Control bits 3-5: slot, row, FOT overhead
// - Control bits 6-7: integration block flags
// - Constant bits; idle control word 512
// - Integration flags low during FOT
// - Two test pins mirror selected flag
// - Control word width follows pixel width
// - Training word on lanes when not valid
// - Twelve-bit training word register, 10-bit trimmed
// - Control lane never carries training word
// - One-pixel overhead gap between bursts
// - Words serialised LSB first
`timescale 1ns/1ps
module slrmc_readout (
	input  wire logic         i_ref_clk,
	input  wire logic         i_rst,
	input  wire logic         i_pix_clk,
	input  wire logic         i_reg_wr,
	input  wire logic [6:0]   i_reg_addr,
	input  wire logic [7:0]   i_reg_wdata,
	output logic      [7:0]   o_reg_rdata,
	input  wire logic [1:0]   i_lane_mode,
	input  wire logic         i_bit12,
	input  wire logic         i_frame_start,
	input  wire logic         i_fot,
	input  wire logic         i_integrating_block_one,
	input  wire logic         i_integrating_block_two,
	input  wire logic [191:0] i_ch_data,
	output logic              o_pix_take,
	output logic      [2:0]   o_slot_idx,
	output logic      [191:0] o_lane_word,
	output logic      [11:0]  o_ctrl_word,
	output logic              o_test_pin_one,
	output logic              o_test_pin_two
);
	slrmc_pkg::slrmc_ref_t r;
	slrmc_pkg::slrmc_ref_t r_nxt;
	slrmc_pkg::slrmc_pix_t p;
	slrmc_pkg::slrmc_pix_t p_nxt;
	logic [1:0]            eff_mode;
	logic [11:0]           wmask;

	// Flag chosen for a test pin; unknown codes show integration block 1
	function automatic logic sel_flag(input logic [7:0] sel, input logic [11:0] ctrl);
		logic f;
		f = ctrl[slrmc_pkg::CB_INTEGRATING_BLOCK_ONE];
		case (sel)
			slrmc_pkg::SEL_INTEGRATING_BLOCK_TWO: f = ctrl[slrmc_pkg::CB_INTEGRATING_BLOCK_TWO];
			slrmc_pkg::SEL_PIXEL_VALID_FLAG:  f = ctrl[slrmc_pkg::CB_PIXEL_VALID_FLAG];
			slrmc_pkg::SEL_ROW_VALID_FLAG:  f = ctrl[slrmc_pkg::CB_ROW_VALID_FLAG];
			slrmc_pkg::SEL_FRAME_VALID_FLAG:  f = ctrl[slrmc_pkg::CB_FRAME_VALID_FLAG];
			default:              f = ctrl[slrmc_pkg::CB_INTEGRATING_BLOCK_ONE];
		endcase
		return f;
	endfunction : sel_flag

	// Register domain: register file, read mux, config handshake source
	always_comb begin
		slrmc_pkg::slrmc_cfg_t cur;
		cur   = '0;
		r_nxt = r;
		if (i_reg_wr) begin
			case (i_reg_addr)
				slrmc_pkg::ADDR_TRAIN_LO: r_nxt.train[slrmc_pkg::DATA_W-1:0] = i_reg_wdata;
				slrmc_pkg::ADDR_TRAIN_HI: r_nxt.train[slrmc_pkg::WORD_W-1:slrmc_pkg::DATA_W] =
					i_reg_wdata[slrmc_pkg::WORD_W-slrmc_pkg::DATA_W-1:0];
				slrmc_pkg::ADDR_SEL_ONE:  r_nxt.sel_one = i_reg_wdata;
				slrmc_pkg::ADDR_SEL_TWO:  r_nxt.sel_two = i_reg_wdata;
				slrmc_pkg::ADDR_DIS_LO:   r_nxt.dis[slrmc_pkg::DATA_W-1:0] = i_reg_wdata;
				slrmc_pkg::ADDR_DIS_HI:   r_nxt.dis[slrmc_pkg::NUM_LANES-1:slrmc_pkg::DATA_W] =
					i_reg_wdata;
				slrmc_pkg::ADDR_ROWS_LO:  r_nxt.rows[slrmc_pkg::DATA_W-1:0] = i_reg_wdata;
				slrmc_pkg::ADDR_ROWS_HI:  r_nxt.rows[slrmc_pkg::ROWS_W-1:slrmc_pkg::DATA_W] =
					i_reg_wdata[slrmc_pkg::ROWS_W-slrmc_pkg::DATA_W-1:0];
				default: ;
			endcase
		end
		// Registered read data, one cycle behind the address
		r_nxt.rdata = 8'h00;
		case (i_reg_addr)
			slrmc_pkg::ADDR_TRAIN_LO: r_nxt.rdata = r.train[slrmc_pkg::DATA_W-1:0];
			slrmc_pkg::ADDR_TRAIN_HI: r_nxt.rdata =
				{4'h0, r.train[slrmc_pkg::WORD_W-1:slrmc_pkg::DATA_W]};
			slrmc_pkg::ADDR_SEL_ONE:  r_nxt.rdata = r.sel_one;
			slrmc_pkg::ADDR_SEL_TWO:  r_nxt.rdata = r.sel_two;
			slrmc_pkg::ADDR_DIS_LO:   r_nxt.rdata = r.dis[slrmc_pkg::DATA_W-1:0];
			slrmc_pkg::ADDR_DIS_HI:   r_nxt.rdata = r.dis[slrmc_pkg::NUM_LANES-1:slrmc_pkg::DATA_W];
			slrmc_pkg::ADDR_ROWS_LO:  r_nxt.rdata = r.rows[slrmc_pkg::DATA_W-1:0];
			slrmc_pkg::ADDR_ROWS_HI:  r_nxt.rdata =
				{5'h00, r.rows[slrmc_pkg::ROWS_W-1:slrmc_pkg::DATA_W]};
			slrmc_pkg::ADDR_STATUS: begin
				r_nxt.rdata[slrmc_pkg::ST_FRAME] = r.fv_s2;
				r_nxt.rdata[slrmc_pkg::ST_BUSY]  = r.busy;
			end
			default: r_nxt.rdata = 8'h00;
		endcase
		// Synchronisers from the pixel domain
		r_nxt.ack_s1 = p.ack;
		r_nxt.ack_s2 = r.ack_s1;
		r_nxt.fv_s1  = p.ctrl[slrmc_pkg::CB_FRAME_VALID_FLAG];
		r_nxt.fv_s2  = r.fv_s1;
		// Shadow stays frozen while a transfer is in flight, so the far side samples a stable word
		cur.train   = r.train;
		cur.sel_one = r.sel_one;
		cur.sel_two = r.sel_two;
		cur.rows    = r.rows;
		cur.dis     = r.dis;
		cur.mode    = i_lane_mode;
		cur.bit12   = i_bit12;
		if (r.busy) begin
			if (r.ack_s2 == r.req) begin
				r_nxt.busy = 1'b0;
			end
		end else if (cur != r.sh) begin
			r_nxt.sh   = cur;
			r_nxt.req  = ~r.req;
			r_nxt.busy = 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			r            <= '0;
			r.train      <= slrmc_pkg::TRAIN_RST;
			r.sel_one    <= slrmc_pkg::SEL_RST;
			r.sel_two    <= slrmc_pkg::SEL_RST;
			r.rows       <= slrmc_pkg::ROWS_RST;
			r.dis        <= slrmc_pkg::DIS_RST;
			r.sh.train   <= slrmc_pkg::TRAIN_RST;
			r.sh.sel_one <= slrmc_pkg::SEL_RST;
			r.sh.sel_two <= slrmc_pkg::SEL_RST;
			r.sh.rows    <= slrmc_pkg::ROWS_RST;
			r.sh.dis     <= slrmc_pkg::DIS_RST;
			r.sh.mode    <= slrmc_pkg::MODE_16;
		end else begin
			r <= r_nxt;
		end
	end

	// Effective mode: 12-bit conversion is too slow for more than four lanes
	always_comb begin
		eff_mode = p.cfg.mode;
		if (p.cfg.bit12 && (p.cfg.mode == slrmc_pkg::MODE_16 || p.cfg.mode == slrmc_pkg::MODE_8)) begin
			eff_mode = slrmc_pkg::MODE_4;
		end
		wmask = p.cfg.bit12 ? slrmc_pkg::MASK_12 : slrmc_pkg::MASK_10;
	end

	// Pixel domain: burst sequencer, lane mux, control word
	always_comb begin
		logic [3:0]  slots_m1;
		logic [3:0]  src_mask;
		logic        last_slot;
		logic        last_row;
		logic        dv;
		logic [11:0] word;
		int          src;
		slots_m1  = 4'((4'h1 << eff_mode) - 4'h1);
		src_mask  = ~slots_m1;
		last_slot = ({1'b0, p.slot} == slots_m1);
		last_row  = (11'(p.row + 11'h001) >= p.cfg.rows);
		dv        = (p.st == slrmc_pkg::ST_BURST);
		word      = '0;
		src       = 0;
		p_nxt     = p;
		// Toggle handshake sink; first stage only feeds the second
		p_nxt.req_s1 = r.req;
		p_nxt.req_s2 = p.req_s1;
		if (p.req_s2 != p.ack) begin
			p_nxt.cfg = r.sh;
			p_nxt.ack = p.req_s2;
		end
		// Each slot is one overhead pixel then a 128-pixel burst
		case (p.st)
			slrmc_pkg::ST_IDLE: begin
				if (i_frame_start) begin
					p_nxt.st   = slrmc_pkg::ST_GAP;
					p_nxt.slot = 3'h0;
					p_nxt.row  = 11'h000;
				end
			end
			slrmc_pkg::ST_GAP: begin
				p_nxt.st  = slrmc_pkg::ST_BURST;
				p_nxt.pix = 7'h00;
			end
			slrmc_pkg::ST_BURST: begin
				p_nxt.pix = 7'(p.pix + 7'h01);
				if (p.pix == slrmc_pkg::PIX_LAST) begin
					p_nxt.st = slrmc_pkg::ST_GAP;
					if (last_slot) begin
						p_nxt.slot = 3'h0;
						if (last_row) begin
							p_nxt.st = slrmc_pkg::ST_IDLE;
						end else begin
							p_nxt.row = 11'(p.row + 11'h001);
						end
					end else begin
						p_nxt.slot = 3'(p.slot + 3'h1);
					end
				end
			end
			default: p_nxt.st = slrmc_pkg::ST_IDLE;
		endcase
		// Control word, never the training word
		p_nxt.ctrl                      = slrmc_pkg::CTRL_CONST;
		p_nxt.ctrl[slrmc_pkg::CB_PIXEL_VALID_FLAG]  = dv;
		p_nxt.ctrl[slrmc_pkg::CB_ROW_VALID_FLAG]  = (p.st != slrmc_pkg::ST_IDLE);
		p_nxt.ctrl[slrmc_pkg::CB_FRAME_VALID_FLAG]  = (p.st != slrmc_pkg::ST_IDLE);
		p_nxt.ctrl[slrmc_pkg::CB_SLOT]  = (p.st == slrmc_pkg::ST_GAP);
		p_nxt.ctrl[slrmc_pkg::CB_ROW]   = (p.st == slrmc_pkg::ST_GAP) && (p.slot == 3'h0);
		p_nxt.ctrl[slrmc_pkg::CB_FOT]   = i_fot;
		p_nxt.ctrl[slrmc_pkg::CB_INTEGRATING_BLOCK_ONE] = i_integrating_block_one & ~i_fot;
		p_nxt.ctrl[slrmc_pkg::CB_INTEGRATING_BLOCK_TWO] = i_integrating_block_two & ~i_fot;
		p_nxt.ctrl                      = p_nxt.ctrl & wmask;
		// Each enabled output carries its source lane or the training word, a disabled one zero; bit 0 serialises first
		for (int k = 0; k < slrmc_pkg::NUM_LANES; k++) begin
			src  = k & int'(src_mask);
			word = dv ? i_ch_data[src*slrmc_pkg::WORD_W +: slrmc_pkg::WORD_W] : p.cfg.train;
			if (p.cfg.dis[k]) begin
				word = '0;
			end
			p_nxt.lane[k*slrmc_pkg::WORD_W +: slrmc_pkg::WORD_W] = word & wmask;
		end
		p_nxt.tp_one = sel_flag(p.cfg.sel_one, p_nxt.ctrl);
		p_nxt.tp_two = sel_flag(p.cfg.sel_two, p_nxt.ctrl);
	end

	always_ff @(posedge i_pix_clk or posedge i_rst) begin
		if (i_rst) begin
			p               <= '0;
			p.st            <= slrmc_pkg::ST_IDLE;
			p.cfg.train     <= slrmc_pkg::TRAIN_RST;
			p.cfg.sel_one   <= slrmc_pkg::SEL_RST;
			p.cfg.sel_two   <= slrmc_pkg::SEL_RST;
			p.cfg.rows      <= slrmc_pkg::ROWS_RST;
			p.cfg.dis       <= slrmc_pkg::DIS_RST;
			p.cfg.mode      <= slrmc_pkg::MODE_16;
			p.ctrl          <= slrmc_pkg::CTRL_CONST;
		end else begin
			p <= p_nxt;
		end
	end

	// Outputs; the source must present slot data while take is high
	assign o_pix_take     = (p.st == slrmc_pkg::ST_BURST);
	assign o_slot_idx     = p.slot;
	assign o_lane_word    = p.lane;
	assign o_ctrl_word    = p.ctrl;
	assign o_test_pin_one = p.tp_one;
	assign o_test_pin_two = p.tp_two;
	assign o_reg_rdata    = r.rdata;

	idle_ctrl_a: assert property (@(posedge i_pix_clk) disable iff (i_rst)
		(p.st == slrmc_pkg::ST_IDLE && !i_fot && !i_integrating_block_one && !i_integrating_block_two)
		|=> (o_ctrl_word == slrmc_pkg::CTRL_CONST))
		else $error("idle control word is not 512");

	inte_fot_a: assert property (@(posedge i_pix_clk) disable iff (i_rst)
		o_ctrl_word[slrmc_pkg::CB_FOT]
		|-> !o_ctrl_word[slrmc_pkg::CB_INTEGRATING_BLOCK_ONE] && !o_ctrl_word[slrmc_pkg::CB_INTEGRATING_BLOCK_TWO])
		else $error("integration flag high during FOT");

	one_gap_a: assert property (@(posedge i_pix_clk) disable iff (i_rst)
		($fell(o_ctrl_word[slrmc_pkg::CB_PIXEL_VALID_FLAG]) && o_ctrl_word[slrmc_pkg::CB_FRAME_VALID_FLAG])
		|-> o_ctrl_word[slrmc_pkg::CB_SLOT] ##1 o_ctrl_word[slrmc_pkg::CB_PIXEL_VALID_FLAG])
		else $error("overhead gap is not one pixel");

	burst_len_a: assert property (@(posedge i_pix_clk) disable iff (i_rst)
		(p.st == slrmc_pkg::ST_GAP) |=> (p.st == slrmc_pkg::ST_BURST && p.pix == 7'h00)
		##127 (p.st == slrmc_pkg::ST_BURST && p.pix == slrmc_pkg::PIX_LAST))
		else $error("burst is not 128 pixels");

	train_fill_a: assert property (@(posedge i_pix_clk) disable iff (i_rst)
		(!o_ctrl_word[slrmc_pkg::CB_PIXEL_VALID_FLAG] && !$past(p.cfg.dis[0]))
		|-> (o_lane_word[slrmc_pkg::WORD_W-1:0] == ($past(p.cfg.train) & $past(wmask))))
		else $error("training word missing on lane one");

	lane_dup_a: assert property (@(posedge i_pix_clk) disable iff (i_rst)
		($past(eff_mode) == slrmc_pkg::MODE_8 && $past(p.cfg.dis[1:0]) == 2'h0)
		|-> (o_lane_word[2*slrmc_pkg::WORD_W-1:slrmc_pkg::WORD_W]
		== o_lane_word[slrmc_pkg::WORD_W-1:0]))
		else $error("even lane does not copy odd lane");

	twelve_bit_a: assert property (@(posedge i_pix_clk) disable iff (i_rst)
		p.cfg.bit12 |-> (eff_mode == slrmc_pkg::MODE_4 || eff_mode == slrmc_pkg::MODE_2))
		else $error("12-bit mode uses more than four lanes");

	test_pin_a: assert property (@(posedge i_pix_clk) disable iff (i_rst)
		($past(p.cfg.sel_one) == slrmc_pkg::SEL_PIXEL_VALID_FLAG)
		|-> (o_test_pin_one == o_ctrl_word[slrmc_pkg::CB_PIXEL_VALID_FLAG]))
		else $error("test pin one does not follow data valid");

	frame_end_a: assert property (@(posedge i_pix_clk) disable iff (i_rst)
		$fell(o_ctrl_word[slrmc_pkg::CB_FRAME_VALID_FLAG]) |-> $past(o_ctrl_word[slrmc_pkg::CB_PIXEL_VALID_FLAG]))
		else $error("frame ended outside a burst");

	cfg_xfer_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		$rose(r.busy) |-> ##[1:40] !r.busy)
		else $error("configuration transfer stalled");
endmodule : slrmc_readout

// >>> sim/slrmc_rx_model.sv
`timescale 1ns/1ps
// Host receiver: judges the lanes by the control flags alone
module slrmc_rx_model (
	input  wire logic         i_pix_clk,
	input  wire logic [191:0] i_lane_word,
	input  wire logic [11:0]  i_ctrl_word,
	output int                o_pixel_valid_flag_cnt,
	output int                o_frame_valid_flag_cnt,
	output logic      [191:0] o_pix_seen,
	output logic      [191:0] o_train_seen
);
	logic frame_valid_flag_d = 1'b0;

	// Counts restart at each frame so every frame is judged on its own
	always @(posedge i_pix_clk) begin
		frame_valid_flag_d <= i_ctrl_word[2];
		if (i_ctrl_word[2] && !frame_valid_flag_d) begin
			o_frame_valid_flag_cnt <= 1;
			o_pixel_valid_flag_cnt <= int'(i_ctrl_word[0]);
		end else if (i_ctrl_word[2]) begin
			o_frame_valid_flag_cnt <= o_frame_valid_flag_cnt + 1;
			o_pixel_valid_flag_cnt <= o_pixel_valid_flag_cnt + int'(i_ctrl_word[0]);
		end
		// Capture pixels on the valid flag, training word in overhead gaps while frame valid is high
		if (i_ctrl_word[0])
			o_pix_seen <= i_lane_word;
		else if (i_ctrl_word[2])
			o_train_seen <= i_lane_word;
	end
endmodule : slrmc_rx_model

// >>> sim/slrmc_readout_bench.sv
`timescale 1ns/1ps
module slrmc_readout_bench;
	logic         i_ref_clk     = 1'b0;
	logic         i_pix_clk     = 1'b0;
	logic         i_rst         = 1'b1;
	logic         i_reg_wr      = 1'b0;
	logic [6:0]   i_reg_addr    = 7'h00;
	logic [7:0]   i_reg_wdata   = 8'h00;
	logic [1:0]   i_lane_mode   = 2'h0;
	logic         i_bit12       = 1'b0;
	logic         i_frame_start = 1'b0;
	logic         i_fot         = 1'b0;
	logic         i_integrating_block_one       = 1'b0;
	logic         i_integrating_block_two       = 1'b0;
	logic [191:0] i_ch_data;
	logic [7:0]   o_reg_rdata;
	logic [191:0] o_lane_word;
	logic [11:0]  o_ctrl_word;
	logic         o_test_pin_one;
	logic         o_test_pin_two;
	logic         o_pix_take;
	logic [2:0]   o_slot_idx;
	int           take_cnt      = 0;
	int           slot_max      = 0;
	logic [191:0] rx_pix;
	logic [191:0] rx_train;
	logic [15:0]  dis           = 16'h0000;
	logic         watch         = 1'b0;
	int           rx_pixel_valid_flag;
	int           rx_frame_valid_flag;
	int           fail_count    = 0;
	int           total_checks  = 0;
	int           pin_err       = 0;
	int           cyc           = 0;
	localparam logic [11:0] TRAIN = 12'hABC;
	localparam int          ROWS  = 2;

	// Unrelated clocks: 50 MHz register side, 32 ns pixel side
	always #10 i_ref_clk = ~i_ref_clk;
	always #16 i_pix_clk = ~i_pix_clk;

	slrmc_readout i_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_pix_clk(i_pix_clk),
		.i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
		.o_reg_rdata(o_reg_rdata), .i_lane_mode(i_lane_mode), .i_bit12(i_bit12),
		.i_frame_start(i_frame_start), .i_fot(i_fot), .i_integrating_block_one(i_integrating_block_one),
		.i_integrating_block_two(i_integrating_block_two), .i_ch_data(i_ch_data), .o_pix_take(o_pix_take),
		.o_slot_idx(o_slot_idx),
		.o_lane_word(o_lane_word), .o_ctrl_word(o_ctrl_word),
		.o_test_pin_one(o_test_pin_one), .o_test_pin_two(o_test_pin_two));

	slrmc_rx_model i_rx (.i_pix_clk(i_pix_clk), .i_lane_word(o_lane_word),
		.i_ctrl_word(o_ctrl_word), .o_pixel_valid_flag_cnt(rx_pixel_valid_flag), .o_frame_valid_flag_cnt(rx_frame_valid_flag),
		.o_pix_seen(rx_pix), .o_train_seen(rx_train));

	// Pins and constant bits are watched every pixel cycle of a frame
	always @(negedge i_pix_clk) begin
		if (watch && (o_test_pin_one !== o_ctrl_word[0] || o_test_pin_two !== o_ctrl_word[2]
			|| o_ctrl_word[11:8] !== 4'h2))
			pin_err++;
		// Pixel requests and highest slot index of the frame
		if (watch && o_pix_take === 1'b1) begin
			take_cnt++;
			if (int'(o_slot_idx) > slot_max)
				slot_max = int'(o_slot_idx);
		end
	end

	// Hang guard, well above the expected run length
	always @(posedge i_ref_clk) begin
		cyc++;
		if (cyc == 30000) begin
			fail_count++;
			complete_run();
		end
	end

	function automatic logic [11:0] chan(input int c);
		return 12'h800 + 12'(c * 17);
	endfunction : chan

	// Output k carries the lowest channel of its group of slots
	function automatic logic [191:0] exp_lanes(input int slots, input logic b12,
		input logic gap);
		logic [191:0] r;
		logic [11:0]  v;
		r = '0;
		for (int k = 0; k < 16; k++) begin
			v = gap ? TRAIN : chan(k & ~(slots - 1));
			v &= b12 ? 12'hFFF : 12'h3FF;
			r[k*12+:12] = dis[k] ? 12'h000 : v;
		end
		return r;
	endfunction : exp_lanes

	task automatic check(input logic [191:0] seen, input logic [191:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : check

	task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge i_ref_clk);
		i_reg_wr = 1'b1;
		i_reg_addr = a;
		i_reg_wdata = d;
		@(negedge i_ref_clk);
		i_reg_wr = 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [6:0] a, input logic [7:0] exp);
		@(negedge i_ref_clk);
		i_reg_addr = a;
		@(negedge i_ref_clk);
		check(o_reg_rdata, exp, "register read");
	endtask : reg_rd

	// Idle flag inputs settle through the pixel pipeline before a look
	task automatic idle_flags(input logic f, input logic a, input logic b, input logic [11:0] e);
		@(negedge i_pix_clk);
		i_fot = f;
		i_integrating_block_one = a;
		i_integrating_block_two = b;
		repeat (4) @(negedge i_pix_clk);
		check(o_ctrl_word, e, "idle control word");
	endtask : idle_flags

	task automatic run(input logic [1:0] m, input logic b12, input int slots);
		int n;
		@(negedge i_ref_clk);
		i_lane_mode = m;
		i_bit12 = b12;
		repeat (40) @(negedge i_ref_clk);
		take_cnt = 0;
		slot_max = 0;
		watch = 1'b1;
		@(negedge i_pix_clk) i_frame_start = 1'b1;
		@(negedge i_pix_clk) i_frame_start = 1'b0;
		for (n = 0; n < 20 && o_ctrl_word[2] !== 1'b1; n++) @(negedge i_pix_clk);
		for (n = 0; n < 4000 && o_ctrl_word[2] !== 1'b0; n++) @(negedge i_pix_clk);
		@(negedge i_pix_clk);
		watch = 1'b0;
		check(rx_frame_valid_flag, ROWS * slots * 129, "frame length");
		check(rx_pixel_valid_flag, ROWS * slots * 128, "valid pixel count");
		check(take_cnt, ROWS * slots * 128, "pixel take count");
		check(slot_max, slots - 1, "last slot index");
		check(rx_pix, exp_lanes(slots, b12, 1'b0), "lane data");
		check(rx_train, exp_lanes(slots, b12, 1'b1), "training word");
		$display("test mode %0d bits12 %0d done", m, b12);
	endtask : run

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run

	initial begin
		for (int c = 0; c < 16; c++)
			i_ch_data[c*12+:12] = chan(c);
		repeat (16) @(posedge i_ref_clk);
		@(negedge i_ref_clk) i_rst = 1'b0;
		// Reset values and refused addresses
		reg_rd(slrmc_pkg::ADDR_ROWS_LO, 8'h40);
		reg_rd(slrmc_pkg::ADDR_ROWS_HI, 8'h04);
		reg_rd(slrmc_pkg::ADDR_TRAIN_LO, 8'h00);
		reg_rd(slrmc_pkg::ADDR_SEL_ONE, 8'h00);
		reg_rd(slrmc_pkg::ADDR_DIS_RSV, 8'h00);
		reg_rd(7'h7F, 8'h00);
		check(o_ctrl_word, 12'h200, "idle word after reset");
		$display("test reset done");
		reg_wr(slrmc_pkg::ADDR_TRAIN_LO, TRAIN[7:0]);
		reg_wr(slrmc_pkg::ADDR_TRAIN_HI, {4'h0, TRAIN[11:8]});
		reg_wr(slrmc_pkg::ADDR_ROWS_LO, 8'h02);
		reg_wr(slrmc_pkg::ADDR_ROWS_HI, 8'h00);
		reg_wr(slrmc_pkg::ADDR_SEL_ONE, slrmc_pkg::SEL_PIXEL_VALID_FLAG);
		reg_wr(slrmc_pkg::ADDR_SEL_TWO, slrmc_pkg::SEL_FRAME_VALID_FLAG);
		reg_rd(slrmc_pkg::ADDR_TRAIN_HI, 8'h0A);
		run(slrmc_pkg::MODE_16, 1'b0, 1);
		run(slrmc_pkg::MODE_8, 1'b0, 2);
		// Switch off the second and last outputs
		reg_wr(slrmc_pkg::ADDR_DIS_LO, 8'h02);
		reg_wr(slrmc_pkg::ADDR_DIS_HI, 8'h80);
		reg_rd(slrmc_pkg::ADDR_DIS_HI, 8'h80);
		dis = 16'h8002;
		run(slrmc_pkg::MODE_4, 1'b0, 4);
		run(slrmc_pkg::MODE_2, 1'b0, 8);
		run(slrmc_pkg::MODE_16, 1'b1, 4);
		run(slrmc_pkg::MODE_2, 1'b1, 8);
		check(pin_err, 0, "test pins or constant bits");
		// Every select code while only block one integrates
		idle_flags(1'b0, 1'b1, 1'b0, 12'h240);
		for (int s = 0; s < 5; s++) begin
			reg_wr(slrmc_pkg::ADDR_SEL_ONE, 8'(s));
			reg_wr(slrmc_pkg::ADDR_SEL_TWO, 8'(s));
			repeat (40) @(negedge i_ref_clk);
			check({o_test_pin_one, o_test_pin_two}, {2{s == 0}}, "select code");
		end
		// Pin one back on block one, so the hidden flag is really observed
		reg_wr(slrmc_pkg::ADDR_SEL_ONE, slrmc_pkg::SEL_INTEGRATING_BLOCK_ONE);
		repeat (40) @(negedge i_ref_clk);
		idle_flags(1'b1, 1'b1, 1'b1, 12'h220);
		check(o_test_pin_one, 1'b0, "flag hidden in overhead");
		idle_flags(1'b0, 1'b0, 1'b1, 12'h280);
		idle_flags(1'b0, 1'b0, 1'b0, 12'h200);
		$display("test flags done");
		complete_run();
	end
endmodule : slrmc_readout_bench
